// *** hw/mcc_mac_ctrl.sv ***
`timescale 1ns/1ps
module mcc_mac_ctrl #(
  parameter int NUM_CNT = 38
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  mcc_pkg::mcc_host_req_t  i_host,
  output logic [31:0]             o_host_rdata,
  output logic                    o_host_ack,
  input  mcc_pkg::mcc_strm_t      i_tx,
  output logic                    o_tx_ready,
  output mcc_pkg::mcc_strm_t      o_phy_tx,
  input  mcc_pkg::mcc_strm_t      i_phy_rx,
  output mcc_pkg::mcc_strm_t      o_rx,
  output mcc_pkg::mcc_rx_status_t o_rx_status,
  input  wire logic [NUM_CNT-1:0] i_cnt_event,
  output logic                    o_full_duplex,
  output logic                    o_sqe_check_en,
  output logic                    o_deferral_check_en,
  output logic                    o_mac_reinit
);
  import mcc_pkg::*;

  initial begin
    if (NUM_CNT != NUM_COUNTERS) begin
      $error("counter map is fixed at the documented count");
    end
  end

  // ==========================================================
  // host registers
  logic [31:0]    mc_ff;
  logic [31:0]    nxt_mc;
  logic [31:0]    cs_ff;
  logic [31:0]    nxt_cs;
  logic [31:0]    rdata_ff;
  logic [31:0]    nxt_rdata;
  logic           ack_ff;
  logic           cnt_wr;
  logic           cnt_clr;
  logic [31:0]    cnt_rdata;
  logic           hit_mc;
  logic           hit_cd;
  logic           hit_cs;

  always_comb begin
    hit_mc    = i_host.stb && (i_host.addr == OFF_MAC_CONTROL);
    hit_cd    = i_host.stb && (i_host.addr == OFF_COUNTER_DATA);
    hit_cs    = i_host.stb && (i_host.addr == OFF_COUNTER_SELECT);
    nxt_mc    = mc_ff;
    nxt_cs    = cs_ff;
    nxt_rdata = '0;
    cnt_wr    = hit_cd && i_host.wr && cs_ff[CS_WRITE_MODE];
    cnt_clr   = hit_cd && !i_host.wr && !cs_ff[CS_WRITE_MODE]
                && cs_ff[CS_CLR_ON_RD];
    if (hit_mc && i_host.wr) begin
      // soft reset stays as written; hardware never drops it
      nxt_mc = i_host.wdata & MAC_CONTROL_WMASK;
    end
    if (nxt_mc[MC_SOFT_RST]) begin
      nxt_mc[MC_TX_HALT] = 1'b1;
      nxt_mc[MC_RX_HALT] = 1'b1;
      nxt_mc[MC_TX_EN]   = 1'b0;
      nxt_mc[MC_RX_EN]   = 1'b0;
    end
    if (hit_cs && i_host.wr) begin
      nxt_cs = i_host.wdata & CSEL_WMASK;
    end else if (hit_cd && cs_ff[CS_AUTO_INC]) begin
      nxt_cs[CS_SEL_W-1:0] = cs_ff[CS_SEL_W-1:0] + 6'h01;
    end
    if (hit_mc) begin
      nxt_rdata = mc_ff;
    end else if (hit_cd) begin
      nxt_rdata = cnt_rdata;
    end else if (hit_cs) begin
      nxt_rdata = cs_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mc_ff    <= MAC_CONTROL_RESET;
      cs_ff    <= '0;
      rdata_ff <= '0;
      ack_ff   <= 1'b0;
    end else begin
      mc_ff    <= nxt_mc;
      cs_ff    <= nxt_cs;
      rdata_ff <= i_host.wr ? 32'h0000_0000 : nxt_rdata;
      ack_ff   <= i_host.stb;
    end
  end

  mcc_counter_bank #(
    .NUM (NUM_CNT),
    .W   (32),
    .SW  (CS_SEL_W)
  ) u_cnt (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_event (i_cnt_event),
    .i_sel   (cs_ff[CS_SEL_W-1:0]),
    .i_wr    (cnt_wr),
    .i_wdata (i_host.wdata),
    .i_clr   (cnt_clr),
    .o_rdata (cnt_rdata)
  );

  // ==========================================================
  // mode outputs and soft reset
  logic reinit_ff;
  logic mode_fd_ff;
  logic mode_sqe_ff;
  logic mode_def_ff;
  logic loop_ff;
  logic core_rst;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      reinit_ff   <= 1'b0;
      mode_fd_ff  <= 1'b1;
      mode_sqe_ff <= 1'b0;
      mode_def_ff <= 1'b0;
      loop_ff     <= 1'b0;
    end else begin
      reinit_ff   <= mc_ff[MC_SOFT_RST];
      mode_fd_ff  <= mc_ff[MC_DUPLEX];
      mode_sqe_ff <= mc_ff[MC_SQE];
      mode_def_ff <= !mc_ff[MC_NO_DEFER];
      loop_ff     <= mc_ff[MC_LOOPBACK];
    end
  end

  // the data paths re-initialise while soft reset is held
  assign core_rst = i_rst || reinit_ff;

  // ==========================================================
  // transmit side and loopback steering
  mcc_strm_t tx_s;
  mcc_strm_t phy_tx_ff;
  mcc_strm_t lb_ff;
  mcc_strm_t rx_in;

  mcc_tx_gate u_tx (
    .i_clk      (i_clk),
    .i_rst      (core_rst),
    .i_tx_en    (mc_ff[MC_TX_EN]),
    .i_tx_halt  (mc_ff[MC_TX_HALT]),
    .i_tx       (i_tx),
    .o_tx_ready (o_tx_ready),
    .o_tx       (tx_s)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phy_tx_ff <= '0;
      lb_ff     <= '0;
    end else begin
      // in loopback the line stays idle and frames turn back inside
      phy_tx_ff <= loop_ff ? '0 : tx_s;
      lb_ff     <= loop_ff ? tx_s : '0;
    end
  end

  assign rx_in = loop_ff ? lb_ff : i_phy_rx;

  // ==========================================================
  // receive path
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int b = 0; b < 8; b++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  mcc_rx_state_t       rx_state_ff;
  mcc_rx_state_t       nxt_rx_state;
  logic [15:0]         cnt_ff;
  logic [15:0]         nxt_cnt;
  logic [31:0]         crc_ff;
  logic [31:0]         nxt_crc;
  logic [15:0]         len_ff;
  logic [15:0]         nxt_len;
  logic [3:0][7:0]     dly_ff;
  logic [3:0][7:0]     nxt_dly;
  logic                early_err_ff;
  logic                nxt_early_err;
  logic                late_err_ff;
  logic                nxt_late_err;
  logic                bad_ff;
  logic                nxt_bad;
  logic [1:0]          flush_ff;
  logic [1:0]          nxt_flush;
  mcc_strm_t           rx_out_ff;
  mcc_strm_t           nxt_rx_out;
  mcc_rx_status_t      stat_ff;
  mcc_rx_status_t      nxt_stat;
  logic                take_byte;
  logic                start;
  logic [15:0]         idx;
  logic [15:0]         oidx;
  logic [15:0]         total;
  logic [15:0]         limit;
  logic [31:0]         crc_n;
  logic                padcut;
  logic                crc_bad;
  logic                too_long;
  logic                dropped;

  always_comb begin
    nxt_rx_state  = rx_state_ff;
    nxt_cnt       = cnt_ff;
    nxt_crc       = crc_ff;
    nxt_len       = len_ff;
    nxt_dly       = dly_ff;
    nxt_early_err = early_err_ff;
    nxt_late_err  = late_err_ff;
    nxt_bad       = bad_ff;
    nxt_flush     = flush_ff;
    nxt_rx_out    = '0;
    nxt_stat      = '0;
    // a new frame is refused while halted; one under way completes
    start         = (rx_state_ff == RX_IDLE) && rx_in.valid && rx_in.sof
                    && mc_ff[MC_RX_EN] && !mc_ff[MC_RX_HALT];
    take_byte     = start || ((rx_state_ff == RX_FRAME) && rx_in.valid);
    idx           = start ? 16'h0000 : cnt_ff;
    oidx          = idx - CRC_BYTES;
    total         = idx + 16'h0001;
    limit         = HDR_BYTES + len_ff;
    crc_n         = crc_byte(start ? CRC_INIT : crc_ff, rx_in.data);
    padcut        = mc_ff[MC_PAD_STRIP] && (len_ff < MIN_PAYLOAD)
                    && (idx > LEN_LO_IDX);
    crc_bad       = !mc_ff[MC_NO_CRC_CHK] && (crc_n != CRC_RESIDUE);
    too_long      = !mc_ff[MC_JUMBO_OK] && (total > MAX_FRAME);
    dropped       = mc_ff[MC_DROP_ERR] && (nxt_early_err
                    || (crc_bad && (total <= ERR_WINDOW)));
    if ((rx_state_ff != RX_IDLE) && !mc_ff[MC_RX_EN]) begin
      // abandon: close the frame downstream as errored, then wait for a sof
      nxt_rx_out.eof = 1'b1;
      nxt_rx_out.err = 1'b1;
      nxt_rx_state   = RX_IDLE;
    end else if (take_byte) begin
      nxt_cnt       = total;
      nxt_crc       = crc_n;
      nxt_early_err = (start ? 1'b0 : early_err_ff)
                      || (rx_in.err && (idx < ERR_WINDOW));
      nxt_late_err  = (start ? 1'b0 : late_err_ff) || rx_in.err;
      if (start) begin
        nxt_len = '0;
      end
      if (idx == LEN_HI_IDX) begin
        nxt_len[15:8] = rx_in.data;
      end
      if (idx == LEN_LO_IDX) begin
        nxt_len[7:0] = rx_in.data;
      end
      // four-byte delay holds back what may turn out to be the crc
      if ((idx >= CRC_BYTES) && !(padcut && (oidx >= limit))) begin
        nxt_rx_out.valid = 1'b1;
        nxt_rx_out.sof   = (oidx == 16'h0000);
        nxt_rx_out.data  = dly_ff[3];
      end
      nxt_dly      = {dly_ff[2:0], rx_in.data};
      nxt_rx_state = RX_FRAME;
      if (rx_in.eof) begin
        nxt_bad           = dropped || crc_bad || too_long || nxt_late_err;
        nxt_stat.valid    = !dropped || mc_ff[MC_KEEP_STAT];
        nxt_stat.dropped  = dropped;
        nxt_stat.crc_bad  = crc_bad;
        nxt_stat.too_long = too_long;
        if (dropped) begin
          nxt_stat.size = '0;
        end else if (padcut) begin
          nxt_stat.size = limit;
        end else if (mc_ff[MC_CRC_STRIP]) begin
          nxt_stat.size = (total > CRC_BYTES) ? oidx + 16'h0001 : '0;
        end else begin
          nxt_stat.size = total;
        end
        if (padcut || mc_ff[MC_CRC_STRIP]) begin
          // crc already checked on crc_n above; its bytes never leave
          nxt_rx_out.eof = 1'b1;
          nxt_rx_out.err = nxt_bad;
          nxt_rx_state   = RX_IDLE;
        end else begin
          nxt_flush    = '0;
          nxt_rx_state = RX_FLUSH;
        end
      end
    end else if (rx_state_ff == RX_FLUSH) begin
      // arrivals during the four flush cycles are not taken
      nxt_rx_out.valid = 1'b1;
      nxt_rx_out.data  = dly_ff[3];
      nxt_dly          = {dly_ff[2:0], 8'h00};
      nxt_flush        = flush_ff + 2'b01;
      if (flush_ff == 2'b11) begin
        nxt_rx_out.eof = 1'b1;
        nxt_rx_out.err = bad_ff;
        nxt_rx_state   = RX_IDLE;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      rx_state_ff  <= RX_IDLE;
      cnt_ff       <= '0;
      crc_ff       <= CRC_INIT;
      len_ff       <= '0;
      dly_ff       <= '0;
      early_err_ff <= 1'b0;
      late_err_ff  <= 1'b0;
      bad_ff       <= 1'b0;
      flush_ff     <= '0;
      rx_out_ff    <= '0;
      stat_ff      <= '0;
    end else begin
      rx_state_ff  <= nxt_rx_state;
      cnt_ff       <= nxt_cnt;
      crc_ff       <= nxt_crc;
      len_ff       <= nxt_len;
      dly_ff       <= nxt_dly;
      early_err_ff <= nxt_early_err;
      late_err_ff  <= nxt_late_err;
      bad_ff       <= nxt_bad;
      flush_ff     <= nxt_flush;
      rx_out_ff    <= nxt_rx_out;
      stat_ff      <= nxt_stat;
    end
  end

  // ==========================================================
  // outputs
  assign o_host_rdata        = rdata_ff;
  assign o_host_ack          = ack_ff;
  assign o_phy_tx            = phy_tx_ff;
  assign o_rx                = rx_out_ff;
  assign o_rx_status         = stat_ff;
  assign o_full_duplex       = mode_fd_ff;
  assign o_sqe_check_en      = mode_sqe_ff;
  assign o_deferral_check_en = mode_def_ff;
  assign o_mac_reinit        = reinit_ff;
endmodule : mcc_mac_ctrl

// *** hw/mcc_pkg.sv ***
package mcc_pkg;
  // ==========================================================
  // register map
  localparam int           HOST_AW            = 10;
  localparam logic [9:0]   OFF_MAC_CONTROL    = 10'h154;
  localparam logic [9:0]   OFF_COUNTER_DATA   = 10'h164;
  localparam logic [9:0]   OFF_COUNTER_SELECT = 10'h168;
  localparam logic [31:0]  MAC_CONTROL_RESET  = 32'h0080_0050;
  localparam logic [31:0]  MAC_CONTROL_WMASK  = 32'h0fe3_00f3;
  localparam logic [31:0]  CSEL_WMASK         = 32'h0000_073f;
  // mac_control fields
  localparam int MC_TX_EN      = 27;
  localparam int MC_TX_HALT    = 26;
  localparam int MC_RX_EN      = 25;
  localparam int MC_RX_HALT    = 24;
  localparam int MC_DROP_ERR   = 23;
  localparam int MC_KEEP_STAT  = 22;
  localparam int MC_JUMBO_OK   = 21;
  localparam int MC_SOFT_RST   = 17;
  localparam int MC_LOOPBACK   = 16;
  localparam int MC_PAD_STRIP  = 7;
  localparam int MC_DUPLEX     = 6;
  localparam int MC_SQE        = 5;
  localparam int MC_NO_DEFER   = 4;
  localparam int MC_CRC_STRIP  = 1;
  localparam int MC_NO_CRC_CHK = 0;
  // counter_select_control fields
  localparam int CS_AUTO_INC   = 10;
  localparam int CS_CLR_ON_RD  = 9;
  localparam int CS_WRITE_MODE = 8;
  localparam int CS_SEL_W      = 6;
  localparam int NUM_COUNTERS  = 38;
  // ==========================================================
  // frame figures
  localparam logic [15:0] ERR_WINDOW  = 16'd256;
  localparam logic [15:0] MAX_FRAME   = 16'd1518;
  localparam logic [15:0] HDR_BYTES   = 16'd14;
  localparam logic [15:0] MIN_PAYLOAD = 16'd46;
  localparam logic [15:0] CRC_BYTES   = 16'd4;
  localparam logic [15:0] LEN_HI_IDX  = 16'd12;
  localparam logic [15:0] LEN_LO_IDX  = 16'd13;
  localparam logic [31:0] CRC_INIT    = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY    = 32'hedb8_8320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb_20e3;
  // ==========================================================
  // types
  typedef struct packed {
    logic             stb;
    logic             wr;
    logic [9:0]       addr;
    logic [31:0]      wdata;
  } mcc_host_req_t;
  typedef struct packed {
    logic             valid;
    logic             sof;
    logic             eof;
    logic             err;
    logic [7:0]       data;
  } mcc_strm_t;
  typedef struct packed {
    logic             valid;
    logic             dropped;
    logic             crc_bad;
    logic             too_long;
    logic [15:0]      size;
  } mcc_rx_status_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} mcc_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_FRAME = 3'b010, RX_FLUSH = 3'b100}
    mcc_rx_state_t;
endpackage : mcc_pkg

// *** hw/mcc_tx_gate.sv ***
`timescale 1ns/1ps
module mcc_tx_gate (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_tx_en,
  input  wire logic          i_tx_halt,
  input  mcc_pkg::mcc_strm_t i_tx,
  output logic               o_tx_ready,
  output mcc_pkg::mcc_strm_t o_tx
);
  import mcc_pkg::*;

  mcc_tx_state_t state_ff;
  mcc_tx_state_t nxt_state;
  logic          ready_ff;
  logic          nxt_ready;
  mcc_strm_t     out_ff;
  mcc_strm_t     nxt_out;
  logic          take;

  // ==========================================================
  // frame gating
  always_comb begin
    take      = ready_ff & i_tx.valid;
    nxt_state = state_ff;
    nxt_out   = '0;
    case (state_ff)
      TX_IDLE: begin
        if (take && i_tx_en && i_tx.sof) begin
          nxt_out = i_tx;
          if (!i_tx.eof) begin
            nxt_state = TX_SEND;
          end
        end
      end
      TX_SEND: begin
        if (!i_tx_en) begin
          // abort marker: no data, end with error so the line stops now
          nxt_out.eof = 1'b1;
          nxt_out.err = 1'b1;
          nxt_state   = TX_IDLE;
        end else if (take) begin
          nxt_out = i_tx;
          if (i_tx.eof) begin
            nxt_state = TX_IDLE;
          end
        end
      end
      default: nxt_state = TX_IDLE;
    endcase
    // halt only refuses a new frame; a frame under way runs to its end
    nxt_ready = i_tx_en && ((nxt_state == TX_SEND) || !i_tx_halt);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= TX_IDLE;
      ready_ff <= 1'b0;
      out_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      out_ff   <= nxt_out;
    end
  end

  assign o_tx_ready = ready_ff;
  assign o_tx       = out_ff;
endmodule : mcc_tx_gate

// *** hw/mcc_counter_bank.sv ***
`timescale 1ns/1ps
module mcc_counter_bank #(
  parameter int NUM = 38,
  parameter int W   = 32,
  parameter int SW  = 6
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic [NUM-1:0] i_event,
  input  wire logic [SW-1:0] i_sel,
  input  wire logic          i_wr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic          i_clr,
  output logic [W-1:0]       o_rdata
);
  initial begin
    if (NUM < 1 || NUM > (1 << SW)) begin
      $error("counter count does not fit the select field");
    end
  end

  logic [W-1:0] cnt_ff  [NUM];
  logic [W-1:0] nxt_cnt [NUM];

  // ==========================================================
  // counters
  always_comb begin
    for (int k = 0; k < NUM; k++) begin
      nxt_cnt[k] = cnt_ff[k] + {{(W-1){1'b0}}, i_event[k]};
      if (i_sel == SW'(k)) begin
        if (i_wr) begin
          nxt_cnt[k] = i_wdata;
        end else if (i_clr) begin
          // an event landing on the clear still counts
          nxt_cnt[k] = {{(W-1){1'b0}}, i_event[k]};
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    for (int k = 0; k < NUM; k++) begin
      if (i_rst) begin
        cnt_ff[k] <= '0;
      end else begin
        cnt_ff[k] <= nxt_cnt[k];
      end
    end
  end

  // selects past the last counter read as zero
  assign o_rdata = (int'(i_sel) < NUM) ? cnt_ff[i_sel] : '0;
endmodule : mcc_counter_bank

// *** verification/mcc_mac_ctrl_asserts.sv ***
`timescale 1ns/1ps
// ==========================================================
// port checks
module mcc_mac_ctrl_asserts (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  mcc_pkg::mcc_host_req_t i_host,
  input  wire logic             o_host_ack,
  input  mcc_pkg::mcc_strm_t    i_tx,
  input  wire logic             o_tx_ready,
  input  mcc_pkg::mcc_strm_t    o_phy_tx,
  input  wire logic             o_full_duplex,
  input  wire logic             o_sqe_check_en,
  input  wire logic             o_deferral_check_en,
  input  wire logic             o_mac_reinit
);
  import mcc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic mcr_wr;
  logic lb_ff;
  logic nxt_lb;
  assign mcr_wr = i_host.stb && i_host.wr && (i_host.addr == OFF_MAC_CONTROL);
  // loopback copy kept here because the checker cannot see the register
  always_comb begin
    nxt_lb = lb_ff;
    if (i_rst) nxt_lb = 1'b0;
    else if (mcr_wr) nxt_lb = i_host.wdata[MC_LOOPBACK];
  end
  always_ff @(posedge i_clk) begin
    lb_ff <= nxt_lb;
  end
  sequence s_mcr_wr;
    mcr_wr;
  endsequence
  // writes in the same cycle may abort the byte, so they are left out
  sequence s_tx_take;
    i_tx.valid && o_tx_ready && !lb_ff && !mcr_wr;
  endsequence
  AST_HOST_ACK: assert property (o_host_ack == $past(i_host.stb))
    else $error("host ack does not follow the access by one cycle");
  AST_DUPLEX: assert property (s_mcr_wr |=> ##1
    o_full_duplex == $past(i_host.wdata[MC_DUPLEX], 2))
    else $error("duplex output does not follow the written bit");
  AST_SQE: assert property (s_mcr_wr |=> ##1
    o_sqe_check_en == $past(i_host.wdata[MC_SQE], 2))
    else $error("sqe check output does not follow the written bit");
  AST_DEFER: assert property (s_mcr_wr |=> ##1
    o_deferral_check_en != $past(i_host.wdata[MC_NO_DEFER], 2))
    else $error("deferral check output is not the inverse of the written bit");
  AST_REINIT_HOLD: assert property (o_mac_reinit && !$past(mcr_wr) |=> o_mac_reinit)
    else $error("soft reset dropped without a software write");
  AST_REINIT_STOP: assert property (o_mac_reinit |=> !o_tx_ready)
    else $error("transmit still ready during soft reset");
  AST_TX_PATH: assert property (s_tx_take |-> ##2 o_phy_tx.valid
    && o_phy_tx.sof == $past(i_tx.sof, 2) && o_phy_tx.data == $past(i_tx.data, 2))
    else $error("transmit byte not forwarded two cycles later");
  AST_LOOP_IDLE: assert property (lb_ff && $past(lb_ff, 3) |-> !o_phy_tx.valid)
    else $error("line transmit active in loopback");
endmodule : mcc_mac_ctrl_asserts

bind mcc_mac_ctrl mcc_mac_ctrl_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_host(i_host),
  .o_host_ack(o_host_ack), .i_tx(i_tx), .o_tx_ready(o_tx_ready), .o_phy_tx(o_phy_tx),
  .o_full_duplex(o_full_duplex), .o_sqe_check_en(o_sqe_check_en),
  .o_deferral_check_en(o_deferral_check_en), .o_mac_reinit(o_mac_reinit));

// *** verification/mcc_phy_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// line-side transceiver stand-in
module mcc_phy_model (
  input  wire logic          i_clk,
  input  mcc_pkg::mcc_strm_t i_tx,
  output mcc_pkg::mcc_strm_t o_rx
);
  import mcc_pkg::*;
  int n_tx    = 0;
  int n_abort = 0;
  initial o_rx = '0;
  always @(posedge i_clk) begin
    if (i_tx.valid) n_tx++;
    if (!i_tx.valid && i_tx.eof && i_tx.err) n_abort++;
  end
  task automatic send(input int len, input int err_at);
    for (int k = 0; k < len; k++) begin
      @(posedge i_clk);
      o_rx <= '{1'b1, k == 0, k == len - 1, k == err_at, 8'(k + 48)};
    end
    @(posedge i_clk);
    // released line shows the inverse of the last byte so stale data never matches
    o_rx <= '{1'b0, 1'b0, 1'b0, 1'b0, ~o_rx.data};
    repeat (8) @(posedge i_clk);
  endtask : send
endmodule : mcc_phy_model

// *** verification/test_mac_control_and_counter_data.sv ***
`timescale 1ns/1ps
module test_mac_control_and_counter_data;
  import mcc_pkg::*;
  logic           clk;
  logic           rst;
  mcc_host_req_t  host;
  logic [31:0]    rdata;
  logic           ack;
  mcc_strm_t      tx;
  logic           tx_ready;
  mcc_strm_t      phy_tx;
  mcc_strm_t      phy_rx;
  mcc_rx_status_t status;
  mcc_rx_status_t st;
  logic           fdx;
  logic           sqe;
  logic           dfr;
  logic           reinit;
  int             n_st = 0;
  mcc_strm_t      rx_out;
  int             n_eof = 0;
  logic [37:0]    cnt_ev = '0;
  int             miscompares = 0;
  int             n_checks = 0;
  int             cyc = 0;
  mcc_mac_ctrl i_dut (.i_clk(clk), .i_rst(rst), .i_host(host), .o_host_rdata(rdata),
    .o_host_ack(ack), .i_tx(tx), .o_tx_ready(tx_ready), .o_phy_tx(phy_tx), .i_phy_rx(phy_rx),
    .o_rx(rx_out), .o_rx_status(status), .i_cnt_event(cnt_ev), .o_full_duplex(fdx),
    .o_sqe_check_en(sqe), .o_deferral_check_en(dfr), .o_mac_reinit(reinit));
  mcc_phy_model u_phy (.i_clk(clk), .i_tx(phy_tx), .o_rx(phy_rx));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (status.valid) begin
      st = status;
      n_st++;
    end
    if (rx_out.eof) begin
      n_eof++;
    end
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge clk);
    host <= '{1'b1, w, a, d};
    @(posedge clk);
    host.stb <= 1'b0;
    #1;
    check("ack", {31'h0, ack}, 32'h1);
    if (!w) check("rdata", rdata, e);
  endtask : bus
  task automatic tx_send(input int len, input logic last);
    for (int k = 0; k < len; k++) begin
      @(posedge clk);
      tx <= '{1'b1, k == 0, last && (k == len - 1), 1'b0, 8'(k + 64)};
    end
    @(posedge clk);
    tx.valid <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : tx_send
  // ==========================================================
  // scenarios
  task automatic t_reset();
    bus(0, 10'h154, 0, 32'h0080_0050);
    check("duplex", {31'h0, fdx}, 32'h1);
    check("sqe", {31'h0, sqe}, 32'h0);
    check("deferral", {31'h0, dfr}, 32'h0);
    bus(0, 10'h164, 0, 32'h0);
    bus(0, 10'h158, 0, 32'h0);
  endtask : t_reset
  task automatic t_ctrl();
    bus(1, 10'h154, 32'h0080_0020, 0);
    repeat (2) @(posedge clk);
    check("duplex", {31'h0, fdx}, 32'h0);
    check("sqe", {31'h0, sqe}, 32'h1);
    check("deferral", {31'h0, dfr}, 32'h1);
    bus(1, 10'h154, 32'h0080_0050, 0);
  endtask : t_ctrl
  task automatic t_softrst();
    bus(1, 10'h154, 32'h0a82_0050, 0);
    repeat (20) @(posedge clk);
    check("reinit", {31'h0, reinit}, 32'h1);
    bus(0, 10'h154, 0, 32'h0582_0050);
    bus(1, 10'h154, 32'h0080_0050, 0);
    bus(0, 10'h154, 0, 32'h0080_0050);
  endtask : t_softrst
  task automatic t_cnt();
    bus(1, 10'h168, 32'h524, 0);
    bus(1, 10'h164, 32'ha5, 0);
    bus(1, 10'h164, 32'h5a, 0);
    bus(0, 10'h168, 0, 32'h526);
    bus(1, 10'h168, 32'h624, 0);
    bus(0, 10'h164, 0, 32'ha5);
    bus(0, 10'h164, 0, 32'h5a);
    bus(1, 10'h168, 32'h024, 0);
    @(posedge clk);
    cnt_ev[36] <= 1'b1;
    @(posedge clk);
    cnt_ev[36] <= 1'b0;
    bus(0, 10'h164, 0, 32'h1);
  endtask : t_cnt
  task automatic t_tx();
    bus(1, 10'h154, 32'h0880_0050, 0);
    tx_send(3, 1'b1);
    check("line bytes", 32'(u_phy.n_tx), 32'd3);
    tx_send(2, 1'b0);
    bus(1, 10'h154, 32'h0080_0050, 0);
    repeat (4) @(posedge clk);
    check("abort", 32'(u_phy.n_abort), 32'd1);
    check("ready", {31'h0, tx_ready}, 32'h0);
    bus(1, 10'h154, 32'h0c80_0050, 0);
    repeat (3) @(posedge clk);
    check("ready", {31'h0, tx_ready}, 32'h0);
  endtask : t_tx
  task automatic t_rx();
    // crc check off is never combined with crc strip
    bus(1, 10'h154, 32'h02c0_0050, 0);
    u_phy.send(8, 2);
    check("status count", 32'(n_st), 32'd1);
    check("dropped", {31'h0, st.dropped}, 32'h1);
    check("size", {16'h0, st.size}, 32'h0);
    bus(1, 10'h154, 32'h0280_0050, 0);
    u_phy.send(8, 2);
    check("status count", 32'(n_st), 32'd1);
    bus(1, 10'h154, 32'h0240_0051, 0);
    u_phy.send(8, 2);
    check("dropped", {31'h0, st.dropped}, 32'h0);
    check("crc bad", {31'h0, st.crc_bad}, 32'h0);
    bus(1, 10'h154, 32'h0240_0052, 0);
    u_phy.send(8, -1);
    check("size", {16'h0, st.size}, 32'd4);
    check("rx ends", 32'(n_eof), 32'd4);
    bus(1, 10'h154, 32'h0240_0051, 0);
    u_phy.send(1519, -1);
    check("too long", {31'h0, st.too_long}, 32'h1);
    bus(1, 10'h154, 32'h0260_0051, 0);
    u_phy.send(1519, -1);
    check("too long", {31'h0, st.too_long}, 32'h0);
    bus(1, 10'h154, 32'h0340_0051, 0);
    u_phy.send(8, -1);
    check("status count", 32'(n_st), 32'd5);
    check("rx ends", 32'(n_eof), 32'd6);
    bus(1, 10'h154, 32'h0240_0051, 0);
    // receive enable drops while the frame is still arriving
    fork
      u_phy.send(40, -1);
      begin
        repeat (10) @(posedge clk);
        bus(1, 10'h154, 32'h0040_0051, 0);
      end
    join
    check("status count", 32'(n_st), 32'd5);
    check("rx ends", 32'(n_eof), 32'd7);
  endtask : t_rx
  task automatic t_loop();
    int n;
    n = u_phy.n_tx;
    bus(1, 10'h154, 32'h0ac1_0050, 0);
    tx_send(6, 1'b1);
    check("line bytes", 32'(u_phy.n_tx), 32'(n));
    check("status count", 32'(n_st), 32'd6);
  endtask : t_loop
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial begin
    rst  = 1'b1;
    host = '0;
    tx   = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_softrst();
    t_cnt();
    t_tx();
    t_rx();
    t_loop();
    give_verdict();
  end
endmodule : test_mac_control_and_counter_data
